//--- hw/tpc_pkg.sv
// Operation
// - 16-bit counter runs free, to a modulus, or up/down in center mode
// - modulus of all zeros or all ones gives a full-range free-running count
// - reading the counter never disturbs the count sequence
// - any write to either counter byte clears the counter
// - after reset the timer is off and all pins are inputs without pullup
// - a pin used as timer input may have its passive pullup enabled
// - clock select 1:1 drives the prescaler from the synchronised external pin
// - a pin owned by the timer ignores port data and direction
// - overflow flag bit 7 sets when the up counter wraps to zero after modulus
// - in center mode the flag sets on the step down from the modulus
// - flag clears only by status read with flag set then writing 0
// - an overflow during the clear sequence restarts it and keeps the flag
// - overflow interrupt enable bit 6 requests an interrupt while flag is set
// - center-aligned select bit 5 puts all channels in up/down pwm
// - 2-bit clock select at bits 4:3 disables or picks one of three sources
// - 3-bit prescale at bits 2:0 divides the selected clock by 1 to 128
// - each channel is capture, compare or edge-aligned pwm independently
// - capture edge, compare action and pwm polarity are selectable
// - one interrupt per channel plus one overflow interrupt
// - clock select 00 off, 01 bus, 10 fixed system clock, 11 external pin
// - prescale codes 000 to 111 divide by 1,2,4,...,128 in order
// - reading one counter byte latches both until the other byte is read or the counter or status/control is written
package tpc_pkg;
	localparam logic [7:0] REG_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] REG_COUNT_VALUE = 8'h04;
	localparam logic [7:0] REG_MODULUS_VALUE = 8'h08;
	localparam logic [7:0] REG_CH_BASE = 8'h10;
	localparam int CH_STRIDE = 8;
	localparam logic [7:0] CH_VALUE_OFFSET = 8'h04;
	localparam int SC_FLAG_BIT = 7;
	localparam int SC_IRQ_EN_BIT = 6;
	localparam int SC_CENTER_BIT = 5;
	localparam int SC_CLKSEL_HI = 4;
	localparam int SC_CLKSEL_LO = 3;
	localparam int SC_PRESCALE_HI = 2;
	localparam int CH_FLAG_BIT = 7;
	localparam int CH_IRQ_EN_BIT = 6;
	localparam int CH_MODE_HI = 5;
	localparam int CH_MODE_LO = 4;
	localparam int CH_ELS_HI = 3;
	localparam int CH_ELS_LO = 2;
	localparam int CH_PULL_BIT = 0;
	localparam logic [7:0] SC_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] MODULUS_RESET = 16'h0000;
	localparam logic [15:0] COUNT_FULL = 16'hFFFF;
	localparam logic [1:0] CLK_OFF = 2'h0;
	localparam logic [1:0] CLK_BUS = 2'h1;
	localparam logic [1:0] CLK_FIXED = 2'h2;
	localparam logic [1:0] CLK_EXT = 2'h3;
	localparam logic [1:0] MODE_CAPTURE = 2'h0;
	localparam logic [1:0] MODE_COMPARE = 2'h1;
	localparam logic [1:0] ELS_NONE = 2'h0;
	localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
	localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
	localparam logic [1:0] ELS_ANY_SET = 2'h3;
	localparam int PRESCALE_BITS = 7;
	localparam int SYNC_EXT = 0;
	localparam int SYNC_FIXED = 1;
	localparam int SYNC_CH0 = 2;
endpackage

//--- hw/tpc_core.sv
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module tpc_core #(
	parameter int NUM_CH = 2
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// clock sources
	input wire logic external_timer_clock_pin,
	input wire logic fixed_system_clock,
	// channel pins
	input wire logic [NUM_CH-1:0] channel_pin_in,
	output logic [NUM_CH-1:0] channel_pin_out,
	output logic [NUM_CH-1:0] channel_pin_oe,
	output logic [NUM_CH-1:0] channel_pullup_en,
	output logic [NUM_CH-1:0] channel_pin_owned,
	// interrupt requests
	output logic overflow_irq,
	output logic [NUM_CH-1:0] channel_irq
);
	import tpc_pkg::*;
	localparam int NS = NUM_CH + 2;

	// bus address phase
	wire addr_take = hsel & htrans[1] & hready;
	wire [7:0] addr_off = {haddr[7:2], 2'h0};
	wire [3:0] addr_be = (hsize == 3'h0) ? (4'h1 << haddr[1:0]) :
		(hsize == 3'h1) ? (haddr[1] ? 4'hC : 4'h3) : 4'hF;
	wire rd_take = addr_take & ~hwrite;
	logic wr_pend;
	logic [7:0] wr_off;
	logic [3:0] wr_be;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_off <= 8'h00;
			wr_be <= 4'h0;
		end else if (hready) begin
			wr_pend <= addr_take & hwrite;
			wr_off <= addr_off;
			wr_be <= addr_be;
		end
	end

	// write strobes in the data phase, read strobes in the address phase
	wire wr_sc = wr_pend & (wr_off == REG_STATUS_CONTROL) & wr_be[0];
	wire wr_cnt = wr_pend & (wr_off == REG_COUNT_VALUE) & (wr_be[0] | wr_be[1]);
	wire wr_mod = wr_pend & (wr_off == REG_MODULUS_VALUE);
	wire rd_sc = rd_take & (addr_off == REG_STATUS_CONTROL);
	wire rd_cnt = rd_take & (addr_off == REG_COUNT_VALUE);

	// input synchronisers: three flops, a change counts once stages two and three agree
	wire [NS-1:0] async_in = {channel_pin_in, fixed_system_clock, external_timer_clock_pin};
	logic [NS-1:0] sync_rise;
	logic [NS-1:0] sync_fall;
	genvar gs;
	generate
		for (gs = 0; gs < NS; gs++) begin : g_sync
			logic s1, s2, s3, q;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					q <= 1'b0;
				end else begin
					s1 <= async_in[gs];
					s2 <= s1;
					s3 <= s2;
					q <= (s2 == s3) ? s3 : q;
				end
			end
			assign sync_rise[gs] = (s2 == s3) & s3 & ~q;
			assign sync_fall[gs] = (s2 == s3) & ~s3 & q;
		end
	endgenerate

	// status/control and counter state
	logic [7:0] sc;
	logic tof_armed;
	logic [15:0] cnt;
	logic [15:0] modulus;
	logic count_down;
	logic [PRESCALE_BITS-1:0] pres;
	logic stepped;
	logic wrapped;
	wire [1:0] clk_sel = sc[SC_CLKSEL_HI:SC_CLKSEL_LO];
	wire [2:0] ps_sel = sc[SC_PRESCALE_HI:0];
	wire center = sc[SC_CENTER_BIT];
	wire overflow_flag = sc[SC_FLAG_BIT];

	// source select; a slow source only ever yields one pulse per rising edge
	wire src_tick = (clk_sel == CLK_BUS) ? 1'b1 :
		(clk_sel == CLK_FIXED) ? sync_rise[SYNC_FIXED] :
		(clk_sel == CLK_EXT) ? sync_rise[SYNC_EXT] : 1'b0;
	wire [7:0] pmask8 = (8'h01 << ps_sel) - 8'h01;
	wire [PRESCALE_BITS-1:0] pmask = pmask8[PRESCALE_BITS-1:0];
	wire tick = src_tick & ((pres & pmask) == pmask);
	wire [15:0] top = (modulus == 16'h0000) ? COUNT_FULL : modulus;
	wire at_top = (cnt == top);
	wire ovf_evt = tick & at_top & ~count_down;
	wire [15:0] cnt_inc = cnt + 16'h0001;
	wire [15:0] cnt_dec = cnt - 16'h0001;
	wire [15:0] next_cnt = !tick ? cnt :
		(count_down ? ((cnt == 16'h0000) ? cnt_inc : cnt_dec) :
		(at_top ? (center ? cnt_dec : 16'h0000) : cnt_inc));
	wire next_down = center & (count_down ? (cnt != 16'h0000) : at_top);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pres <= '0;
		end else if (wr_cnt | wr_sc) begin
			pres <= '0;
		end else if (src_tick) begin
			pres <= pres + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= COUNT_RESET;
			count_down <= 1'b0;
			stepped <= 1'b0;
			wrapped <= 1'b0;
		end else if (wr_cnt) begin
			cnt <= COUNT_RESET;
			count_down <= 1'b0;
			stepped <= 1'b0;
			wrapped <= 1'b0;
		end else begin
			cnt <= next_cnt;
			count_down <= tick ? next_down : (count_down & center);
			stepped <= tick;
			wrapped <= ovf_evt;
		end
	end

	// an overflow in the clearing cycle wins over the clear
	wire tof_clear = wr_sc & ~hwdata[SC_FLAG_BIT] & tof_armed;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sc <= SC_RESET;
			tof_armed <= 1'b0;
		end else begin
			if (wr_sc) begin
				sc[SC_FLAG_BIT-1:0] <= hwdata[SC_FLAG_BIT-1:0];
			end
			sc[SC_FLAG_BIT] <= ovf_evt | (overflow_flag & ~tof_clear);
			tof_armed <= ~ovf_evt & ~wr_sc & (tof_armed | (rd_sc & overflow_flag));
		end
	end

	assign overflow_irq = overflow_flag & sc[SC_IRQ_EN_BIT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			modulus <= MODULUS_RESET;
		end else if (wr_mod) begin
			if (wr_be[0]) modulus[7:0] <= hwdata[7:0];
			if (wr_be[1]) modulus[15:8] <= hwdata[15:8];
		end
	end

	// coherent byte reads of the counter
	logic [15:0] cnt_buf;
	logic cnt_latched;
	logic pend_hi;
	wire rd_lo = rd_cnt & addr_be[0];
	wire rd_hi = rd_cnt & addr_be[1];
	wire [15:0] cnt_view = cnt_latched ? cnt_buf : cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_buf <= COUNT_RESET;
			cnt_latched <= 1'b0;
			pend_hi <= 1'b0;
		end else if (wr_cnt | wr_sc) begin
			cnt_latched <= 1'b0;
		end else if (cnt_latched) begin
			if (pend_hi ? rd_hi : rd_lo) cnt_latched <= 1'b0;
		end else if (rd_lo ^ rd_hi) begin
			cnt_buf <= cnt;
			cnt_latched <= 1'b1;
			pend_hi <= rd_lo;
		end
	end

	// channels
	logic [7:0] ch_ctrl_rd [NUM_CH];
	logic [15:0] ch_val_rd [NUM_CH];
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
			localparam logic [7:0] CTRL_OFF = 8'(REG_CH_BASE + gc * CH_STRIDE);
			localparam logic [7:0] VAL_OFF = 8'(CTRL_OFF + CH_VALUE_OFFSET);
			logic flag, ie, armed, pull, pin;
			logic [1:0] mode, els;
			logic [15:0] val;
			wire wr_ctrl = wr_pend & (wr_off == CTRL_OFF) & wr_be[0];
			wire wr_val = wr_pend & (wr_off == VAL_OFF);
			wire rd_ctrl = rd_take & (addr_off == CTRL_OFF);
			wire is_capture = ~center & (mode == MODE_CAPTURE);
			wire is_compare = ~center & (mode == MODE_COMPARE);
			wire is_epwm = ~center & mode[1];
			wire high_true = (els == ELS_FALL_CLEAR);
			wire edge_hit = ((els == ELS_RISE_TOGGLE) & sync_rise[SYNC_CH0 + gc]) |
				((els == ELS_FALL_CLEAR) & sync_fall[SYNC_CH0 + gc]) |
				((els == ELS_ANY_SET) & (sync_rise[SYNC_CH0 + gc] |
				sync_fall[SYNC_CH0 + gc]));
			wire match = stepped & (cnt == val);
			wire cap_evt = is_capture & edge_hit;
			wire ch_evt = cap_evt | (~is_capture & match & (els != ELS_NONE));
			wire next_pin = (is_compare & match) ? ((els == ELS_RISE_TOGGLE) ? ~pin :
				(els == ELS_ANY_SET)) :
				(is_epwm & match) ? ~high_true :
				(is_epwm & wrapped) ? high_true :
				(center & match) ? (count_down ? high_true : ~high_true) : pin;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					{ie, mode, els, pull} <= 6'h00;
					flag <= 1'b0;
					armed <= 1'b0;
					val <= 16'h0000;
					pin <= 1'b0;
				end else begin
					if (wr_ctrl) begin
						ie <= hwdata[CH_IRQ_EN_BIT];
						mode <= hwdata[CH_MODE_HI:CH_MODE_LO];
						els <= hwdata[CH_ELS_HI:CH_ELS_LO];
						pull <= hwdata[CH_PULL_BIT];
					end
					flag <= ch_evt | (flag & ~(wr_ctrl & ~hwdata[CH_FLAG_BIT] & armed));
					armed <= ~ch_evt & ~wr_ctrl & (armed | (rd_ctrl & flag));
					if (cap_evt) begin
						val <= cnt;
					end else if (wr_val) begin
						if (wr_be[0]) val[7:0] <= hwdata[7:0];
						if (wr_be[1]) val[15:8] <= hwdata[15:8];
					end
					pin <= next_pin;
				end
			end
			// capture with no edge selected hands the pin back to the port
			assign channel_pin_owned[gc] = (els != ELS_NONE);
			assign channel_pin_oe[gc] = channel_pin_owned[gc] & ~is_capture;
			assign channel_pin_out[gc] = pin;
			assign channel_pullup_en[gc] = channel_pin_owned[gc] & is_capture & pull;
			assign channel_irq[gc] = flag & ie;
			assign ch_ctrl_rd[gc] = {flag, ie, mode, els, 1'b0, pull};
			assign ch_val_rd[gc] = val;
		end
	endgenerate

	// read data, registered in the address phase
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		if (addr_off == REG_STATUS_CONTROL) rd_mux = {24'h000000, sc};
		if (addr_off == REG_COUNT_VALUE) rd_mux = {16'h0000, cnt_view};
		if (addr_off == REG_MODULUS_VALUE) rd_mux = {16'h0000, modulus};
		for (int i = 0; i < NUM_CH; i++) begin
			if (addr_off == 8'(REG_CH_BASE + i * CH_STRIDE)) rd_mux = {24'h000000, ch_ctrl_rd[i]};
			if (addr_off == 8'(REG_CH_BASE + i * CH_STRIDE + CH_VALUE_OFFSET))
				rd_mux = {16'h0000, ch_val_rd[i]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_take) begin
			hrdata <= rd_mux;
		end
	end

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_wrap_up;
		tick && at_top && !center && !wr_cnt;
	endsequence
	sequence s_turn_down;
		tick && at_top && center && !count_down && !wr_cnt && top != 16'h0000;
	endsequence

	a_up_wrap: assert property (s_wrap_up |=> cnt == 16'h0000 && overflow_flag)
		else $error("up wrap did not clear counter and set flag");
	a_center_turn: assert property (s_turn_down |=> count_down && overflow_flag && cnt == $past(cnt) - 16'h0001)
		else $error("center turn did not step down with flag");
	a_free_full: assert property (tick && !count_down && !wr_cnt
		&& (modulus == 16'h0000 || modulus == COUNT_FULL) && cnt != COUNT_FULL
		|=> cnt == $past(cnt) + 16'h0001)
		else $error("zero modulus did not allow full range");
	a_cnt_write: assert property (wr_cnt |=> cnt == 16'h0000 && !count_down)
		else $error("counter write did not clear counter");
	a_read_quiet: assert property (rd_cnt && !tick && !wr_cnt |=> cnt == $past(cnt))
		else $error("counter read disturbed count");
	a_flag_write1: assert property (wr_sc && hwdata[SC_FLAG_BIT] && overflow_flag |=> overflow_flag)
		else $error("writing one altered overflow flag");
	a_clear_restart: assert property (ovf_evt ##1 wr_sc && !hwdata[SC_FLAG_BIT] |=> overflow_flag)
		else $error("overflow lost by earlier clear");
	a_irq_follow: assert property ($rose(overflow_flag) && sc[SC_IRQ_EN_BIT] |-> overflow_irq)
		else $error("overflow interrupt not raised");
	a_clk_off: assert property (clk_sel == CLK_OFF && !wr_cnt |=> cnt == $past(cnt))
		else $error("counter moved with clock off");
	a_pres_div: assert property (ps_sel == 3'h1 && tick && !wr_sc && !wr_cnt
		|=> !tick)
		else $error("prescale by two ticked on consecutive cycles");
	a_pin_release: assert property (!channel_pin_owned[0] |-> !channel_pin_oe[0]
		&& !channel_pullup_en[0])
		else $error("unowned pin still driven");
	a_latch_hold: assert property (cnt_latched && !rd_cnt && !wr_cnt && !wr_sc
		|=> cnt_latched && $stable(cnt_buf))
		else $error("count buffer released early");

	sequence s_clear_write;
		tof_armed && wr_sc && !hwdata[SC_FLAG_BIT] && !ovf_evt;
	endsequence
	a_flag_clear: assert property (s_clear_write |=> !overflow_flag)
		else $error("armed clear left overflow flag set");
	a_down_step: assert property (tick && count_down && cnt != 16'h0000
		&& !wr_cnt |=> cnt == $past(cnt) - 16'h0001)
		else $error("down count did not step down");
	a_ext_tick: assert property (clk_sel == CLK_EXT && ps_sel == 3'h0
		&& sync_rise[SYNC_EXT] && !center && !wr_cnt && !wr_sc && cnt != top |=> cnt == $past(cnt) + 16'h0001)
		else $error("external clock edge did not step counter");
	a_pull_input: assert property ((channel_pullup_en & channel_pin_oe) == '0)
		else $error("pullup enabled on a driven pin");
endmodule

//--- tb/tpc_pin_model.sv
`timescale 1ns/100ps
module tpc_pin_model #(
	parameter int NUM_CH = 2
) (
	// timer clock sources
	input wire logic ext_run,
	output logic ext_clk,
	output logic fixed_clk,
	// channel pins
	input wire logic [NUM_CH-1:0] pin_out,
	input wire logic [NUM_CH-1:0] pin_oe,
	input wire logic [NUM_CH-1:0] drive,
	output logic [NUM_CH-1:0] pin_in
);
	// free-running, a quarter of the bus rate, phase unrelated to hclk
	initial begin
		fixed_clk = 1'b0;
		#7;
		forever #50 fixed_clk = ~fixed_clk;
	end
	// an eighth of the bus rate, stands low while idle
	initial begin
		ext_clk = 1'b0;
		forever begin
			#100;
			ext_clk = ext_run ? ~ext_clk : 1'b0;
		end
	end
	// the timer's driver wins, else the outside source sets the level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule

//--- tb/test_timer_pwm_counter_core.sv
`timescale 1ns/100ps
module test_timer_pwm_counter_core;
	import tpc_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext_run = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, c1;
	logic [1:0] htrans = 2'h0, drive = 2'h0, pin_in, pin_out, pin_oe, pull, owned, ch_irq;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, ovf_irq, ext_clk, fix_clk;
	int n_fail = 0, tests_run = 0, cyc = 0, t0, m;
	int lo[4] = '{0, 198, 46, 21};
	int hi[4] = '{0, 205, 52, 27};
	always #12.5 hclk = ~hclk;
	tpc_core tpc_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.external_timer_clock_pin(ext_clk), .fixed_system_clock(fix_clk),
		.channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
		.channel_pullup_en(pull), .channel_pin_owned(owned), .overflow_irq(ovf_irq),
		.channel_irq(ch_irq));
	tpc_pin_model tpc_pin_model_i (.ext_run(ext_run), .ext_clk(ext_clk), .fixed_clk(fix_clk),
		.pin_out(pin_out), .pin_oe(pin_oe), .drive(drive), .pin_in(pin_in));
	// single ahb-lite transfer, entered just after a rising edge
	task automatic bus(input logic [7:0] a, input logic wr, input logic [2:0] sz,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= sz;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input logic [31:0] got, input logic [31:0] l, input logic [31:0] h);
		tests_run++;
		if ((got >= l && got <= h) !== 1'b1) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, l, h);
		end
	endtask
	// level outputs are looked at mid-cycle, once register updates have landed
	task automatic irq_is(input logic v);
		@(negedge hclk);
		chk({31'h0, ovf_irq}, {31'h0, v});
		@(posedge hclk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		m = $urandom(61462);
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(REG_STATUS_CONTROL, 1'b0, 3'h2, 32'h0);
		chk(rd, {24'h0, SC_RESET});
		bus(REG_COUNT_VALUE, 1'b0, 3'h2, 32'h0);
		chk(rd, {16'h0, COUNT_RESET});
		bus(8'h40, 1'b0, 3'h2, 32'h0);
		chk(rd, 32'h0);
		chk({22'h0, hresp, ovf_irq, ch_irq, pin_oe, pull, owned}, 32'h0);
		$display("test reset done");
		// channel controls stay 0 so no channel claims the clock pin
		for (int s = 0; s < 4; s++) begin
			m = ($urandom % 2) ? 32'hFFFF : 32'h0;
			ext_run <= (s == 3);
			bus(REG_STATUS_CONTROL, 1'b1, 3'h2, 32'h0);
			bus(REG_MODULUS_VALUE, 1'b1, 3'h2, m);
			bus(REG_COUNT_VALUE, 1'b1, 3'h2, $urandom);
			bus(REG_STATUS_CONTROL, 1'b1, 3'h2, {27'h0, s[1:0], 3'h0});
			repeat (200) @(posedge hclk);
			bus(REG_COUNT_VALUE, 1'b0, 3'h2, 32'h0);
			chk_rng(rd, lo[s], hi[s]);
		end
		$display("test clock sources done");
		bus(REG_STATUS_CONTROL, 1'b1, 3'h2, {27'h0, CLK_BUS, 3'h0});
		bus(REG_COUNT_VALUE, 1'b1, 3'h2, 32'hA5);
		repeat (20) @(posedge hclk);
		bus(REG_COUNT_VALUE, 1'b0, 3'h0, 32'h0);
		chk_rng({24'h0, rd[7:0]}, 20, 26);
		repeat (600) @(posedge hclk);
		bus(8'h05, 1'b0, 3'h0, 32'h0);
		chk({24'h0, rd[15:8]}, 32'h0);
		bus(REG_COUNT_VALUE, 1'b0, 3'h2, 32'h0);
		chk_rng(rd, 620, 640);
		$display("test count reads done");
		for (int p = 0; p < 8; p++) begin
			m = 6 + $urandom % 16;
			// stop the clock first so no overflow can disarm the clear
			bus(REG_STATUS_CONTROL, 1'b1, 3'h2, 32'h0);
			bus(REG_STATUS_CONTROL, 1'b0, 3'h2, 32'h0);
			bus(REG_STATUS_CONTROL, 1'b1, 3'h2, 32'h0);
			bus(REG_MODULUS_VALUE, 1'b1, 3'h2, m);
			bus(REG_COUNT_VALUE, 1'b1, 3'h2, 32'h0);
			bus(REG_STATUS_CONTROL, 1'b1, 3'h2, {24'h0, 2'h1, p[0], CLK_BUS, p[2:0]});
			t0 = cyc;
			while (ovf_irq !== 1'b1) @(posedge hclk);
			chk_rng(cyc - t0, m << p, ((m + 1) << p) + 4);
			bus(REG_COUNT_VALUE, 1'b0, 3'h2, 32'h0);
			c1 = rd;
			bus(REG_COUNT_VALUE, 1'b0, 3'h2, 32'h0);
			if (p < 2) chk({31'h0, rd < c1}, {31'h0, p[0]});
		end
		$display("test overflow timing done");
		bus(REG_STATUS_CONTROL, 1'b1, 3'h2, {27'h0, CLK_BUS, 3'h0});
		do bus(REG_STATUS_CONTROL, 1'b0, 3'h2, 32'h0); while (rd[7] !== 1'b1);
		// a further wrap lands while the clear is armed
		repeat (30) @(posedge hclk);
		bus(REG_STATUS_CONTROL, 1'b1, 3'h2, 32'h0);
		bus(REG_STATUS_CONTROL, 1'b0, 3'h2, 32'h0);
		chk(rd, 32'h80);
		bus(REG_STATUS_CONTROL, 1'b1, 3'h2, 32'h80);
		irq_is(1'b0);
		bus(REG_STATUS_CONTROL, 1'b1, 3'h2, 32'hC0);
		irq_is(1'b1);
		bus(REG_STATUS_CONTROL, 1'b1, 3'h2, 32'h40);
		bus(REG_STATUS_CONTROL, 1'b0, 3'h2, 32'h0);
		chk(rd, 32'hC0);
		bus(REG_STATUS_CONTROL, 1'b1, 3'h2, 32'h40);
		bus(REG_STATUS_CONTROL, 1'b0, 3'h2, 32'h0);
		chk(rd, 32'h40);
		irq_is(1'b0);
		$display("test flag clearing done");
		bus(REG_MODULUS_VALUE, 1'b1, 3'h2, 32'h0);
		bus(REG_COUNT_VALUE, 1'b1, 3'h2, 32'h0);
		bus(8'h1C, 1'b1, 3'h2, 32'h40);
		bus(8'h18, 1'b1, 3'h2, 32'h5C);
		bus(8'h10, 1'b1, 3'h2, 32'h05);
		bus(REG_STATUS_CONTROL, 1'b1, 3'h2, {27'h0, CLK_BUS, 3'h0});
		@(negedge hclk);
		chk({30'h0, owned}, 32'h3);
		chk({30'h0, pull}, 32'h1);
		chk({30'h0, pin_oe}, 32'h2);
		@(posedge hclk);
		drive <= 2'h1;
		repeat (100) @(posedge hclk);
		chk({30'h0, pin_out}, 32'h2);
		chk({30'h0, ch_irq}, 32'h2);
		bus(8'h14, 1'b0, 3'h2, 32'h0);
		chk_rng(rd, 2, 6);
		bus(8'h10, 1'b0, 3'h2, 32'h0);
		chk(rd, 32'h85);
		bus(8'h10, 1'b1, 3'h2, 32'h0);
		@(negedge hclk);
		chk({28'h0, owned, pull}, 32'h8);
		$display("test channels done");
		complete_run();
	end
endmodule
